/* alm_top.sv */
// alm_top: alarm flag bank, source masks, per-lane faults, apb slave
// Operation
// - mask bit 5 hides lane buffer fault
// - mask bit 4 hides pll unlock
// - mask bit 3 hides link-not-running
// - mask bit 2 hides clock realign
// - mask bit 0 hides divider mismatch
// - lane fault sets its lane bit
// - write one clears lane bit, zero keeps
// - persisting fault sets lane bit again
// - clearing status bit 5 clears all lanes
// - lane faults reset to all ones
// - summary high when any unmasked flag other than reserved bit 1 set
// - any lane fault sets status bit 5
// - all alarm flags set after reset
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ns
module alm_top #(
    parameter int unsigned NUM_LANES = alm_pkg::LANES
) (
    input  wire logic                       pclk,                     // bus and block clock
    input  wire logic                       presetn,                  // async reset, active low
    input  wire logic                       psel,                     // apb select
    input  wire logic                       penable,                  // apb enable
    input  wire logic                       pwrite,                   // apb direction
    input  wire logic [alm_pkg::ADDR_W-1:0] paddr,                    // apb byte address
    input  wire logic [alm_pkg::DATA_W-1:0] pwdata,                   // apb write data
    input  wire logic [3:0]                 pstrb,                    // apb byte strobes
    output logic      [alm_pkg::DATA_W-1:0] prdata,                   // apb read data
    output logic                            pready,                   // apb ready
    output logic                            pslverr,                  // apb error
    input  wire logic [NUM_LANES-1:0]       lane_buffer_err,          // per-lane overflow or underflow
    input  wire logic                       serdes_pll_unlock_status, // serializer pll not locked
    input  wire logic                       link_enable,              // link enabled
    input  wire logic                       link_running,             // link in data state
    input  wire logic                       clock_realign_event,      // internal clocks realigned
    input  wire logic                       divider_mismatch,         // clock dividers disagree
    output logic                            alarm_irq                 // summary alarm, level
);

    // -------------------------------------------------------------------
    // parameter check
    // -------------------------------------------------------------------
    if (NUM_LANES < 1 || NUM_LANES > alm_pkg::REG_W) begin : g_bad_lanes
        $error("alm_top: lane count must be 1 to 8");
    end

    // -------------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------------
    logic [NUM_LANES-1:0]         lane_err_s;
    logic [3:0]                   misc_s;
    logic                         pll_s;
    logic                         link_en_s;
    logic                         link_run_s;
    logic                         realign_s;
    logic                         div_s;

    alm_sync #(
        .W (NUM_LANES)
    ) u_sync_lane (
        .clk   (pclk),
        .rst_n (presetn),
        .d     (lane_buffer_err),
        .q     (lane_err_s)
    );

    alm_sync #(
        .W (4)
    ) u_sync_misc (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({serdes_pll_unlock_status, link_enable, link_running, divider_mismatch}),
        .q     (misc_s)
    );

    alm_sync #(
        .W (1)
    ) u_sync_realign (
        .clk   (pclk),
        .rst_n (presetn),
        .d     (clock_realign_event),
        .q     (realign_s)
    );

    assign pll_s      = misc_s[3];
    assign link_en_s  = misc_s[2];
    assign link_run_s = misc_s[1];
    assign div_s      = misc_s[0];

    // -------------------------------------------------------------------
    // apb decode
    // -------------------------------------------------------------------
    logic                         pready_q;
    logic                         pslverr_q;
    logic [alm_pkg::DATA_W-1:0]   prdata_q;
    logic                         setup_phase;
    logic                         wr_take;
    logic                         hit_summary;
    logic                         hit_status;
    logic                         hit_mask;
    logic                         hit_lane;
    logic                         hit_any;
    logic                         wr_status;
    logic                         wr_mask;
    logic                         wr_lane;

    assign setup_phase = psel && !penable && !pready_q;
    assign wr_take     = psel && penable && pready_q && pwrite && !pslverr_q && pstrb[0];
    assign hit_summary = (paddr == {alm_pkg::IDX_SUMMARY, 2'b00});
    assign hit_status  = (paddr == {alm_pkg::IDX_STATUS, 2'b00});
    assign hit_mask    = (paddr == {alm_pkg::IDX_MASK, 2'b00});
    assign hit_lane    = (paddr == {alm_pkg::IDX_LANE, 2'b00});
    assign hit_any     = hit_summary || hit_status || hit_mask || hit_lane;
    assign wr_status   = wr_take && hit_status;
    assign wr_mask     = wr_take && hit_mask;
    assign wr_lane     = wr_take && hit_lane;

    // -------------------------------------------------------------------
    // source mask register
    // -------------------------------------------------------------------
    logic [alm_pkg::REG_W-1:0]    mask_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= alm_pkg::MASK_RST;
        end else if (wr_mask) begin
            mask_q <= pwdata[alm_pkg::REG_W-1:0];
        end
    end

    // -------------------------------------------------------------------
    // per-lane fault record
    // -------------------------------------------------------------------
    logic [NUM_LANES-1:0]         lane_q;
    logic [NUM_LANES-1:0]         lane_set;
    logic [NUM_LANES-1:0]         lane_clr;
    logic                         global_clr;

    assign lane_set   = lane_err_s;
    assign global_clr = wr_status && pwdata[alm_pkg::BIT_LANE];
    assign lane_clr   = (wr_lane ? pwdata[NUM_LANES-1:0] : '0) | (global_clr ? '1 : '0);

    alm_w1c_bank #(
        .W         (NUM_LANES),
        .RST_VALUE (alm_pkg::LANE_RST[NUM_LANES-1:0])
    ) u_lane_bank (
        .clk   (pclk),
        .rst_n (presetn),
        .set   (lane_set),
        .clr   (lane_clr),
        .q     (lane_q)
    );

    // -------------------------------------------------------------------
    // alarm flag bank
    // -------------------------------------------------------------------
    logic [alm_pkg::STATUS_W-1:0] status_q;
    logic [alm_pkg::STATUS_W-1:0] status_set;
    logic [alm_pkg::STATUS_W-1:0] status_clr;

    always_comb begin
        status_set = '0;
        status_set[alm_pkg::BIT_LANE]    = |lane_set;
        status_set[alm_pkg::BIT_PLL]     = pll_s;
        status_set[alm_pkg::BIT_LINK]    = link_en_s && !link_run_s;
        status_set[alm_pkg::BIT_REALIGN] = realign_s;
        status_set[alm_pkg::BIT_DIV]     = div_s;
    end

    assign status_clr = wr_status ? pwdata[alm_pkg::STATUS_W-1:0] : '0;

    alm_w1c_bank #(
        .W         (alm_pkg::STATUS_W),
        .RST_VALUE (alm_pkg::STATUS_RST)
    ) u_status_bank (
        .clk   (pclk),
        .rst_n (presetn),
        .set   (status_set),
        .clr   (status_clr),
        .q     (status_q)
    );

    // -------------------------------------------------------------------
    // summary alarm and interrupt
    // -------------------------------------------------------------------
    logic [alm_pkg::STATUS_W-1:0] unmasked;
    logic                         unmasked_any;
    logic                         summary_q;

    assign unmasked     = status_q & ~mask_q[alm_pkg::STATUS_W-1:0] & alm_pkg::SRC_BITS;
    assign unmasked_any = |unmasked;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            summary_q <= 1'b0;
        end else begin
            summary_q <= unmasked_any;
        end
    end

    assign alarm_irq = summary_q;

    // -------------------------------------------------------------------
    // read path and handshake
    // -------------------------------------------------------------------
    logic [alm_pkg::REG_W-1:0]    rd_val;

    always_comb begin
        rd_val = '0;
        unique case (1'b1)
            hit_summary: rd_val[0] = summary_q;
            hit_status:  rd_val[alm_pkg::STATUS_W-1:0] = status_q;
            hit_mask:    rd_val = mask_q;
            hit_lane:    rd_val[NUM_LANES-1:0] = lane_q;
            default:     rd_val = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup_phase;
            pslverr_q <= setup_phase && !hit_any;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (setup_phase && !pwrite) begin
            prdata_q <= {{(alm_pkg::DATA_W-alm_pkg::REG_W){1'b0}}, rd_val};
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    logic                         first_q;
    logic [NUM_LANES-1:0]         lane_clr_eff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    assign lane_clr_eff = lane_clr & ~lane_set;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable && !pready_q;
    endsequence

    sequence s_access;
        psel && penable && pready;
    endsequence

    property p_apb_ready;
        s_setup |=> s_access or !psel;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("ready not given after setup");

    property p_mask_lane;
        status_q[5] && ((unmasked & 6'h1F) == 6'h00) |=> summary_q == !$past(mask_q[5]);
    endproperty
    a_mask_lane: assert property (p_mask_lane) else $error("lane fault mask wrong");

    property p_mask_pll;
        status_q[4] && ((unmasked & 6'h2F) == 6'h00) |=> summary_q == !$past(mask_q[4]);
    endproperty
    a_mask_pll: assert property (p_mask_pll) else $error("pll unlock mask wrong");

    property p_mask_link;
        status_q[3] && ((unmasked & 6'h37) == 6'h00) |=> summary_q == !$past(mask_q[3]);
    endproperty
    a_mask_link: assert property (p_mask_link) else $error("link alarm mask wrong");

    property p_mask_realign;
        status_q[2] && ((unmasked & 6'h3B) == 6'h00) |=> summary_q == !$past(mask_q[2]);
    endproperty
    a_mask_realign: assert property (p_mask_realign) else $error("realign mask wrong");

    property p_mask_div;
        status_q[0] && ((unmasked & 6'h3E) == 6'h00) |=> summary_q == !$past(mask_q[0]);
    endproperty
    a_mask_div: assert property (p_mask_div) else $error("divider mask wrong");

    property p_lane_set;
        (|lane_set) |=> ((lane_q & $past(lane_set)) == $past(lane_set)) && status_q[5];
    endproperty
    a_lane_set: assert property (p_lane_set) else $error("lane fault not recorded");

    property p_lane_clear;
        (|lane_clr_eff) |=> (lane_q & $past(lane_clr_eff)) == '0;
    endproperty
    a_lane_clear: assert property (p_lane_clear) else $error("lane bit not cleared");

    property p_lane_hold;
        !(|lane_clr) && !(|lane_set) |=> lane_q == $past(lane_q);
    endproperty
    a_lane_hold: assert property (p_lane_hold) else $error("lane bits changed unasked");

    property p_lane_persist;
        (|(lane_clr & lane_set)) |=> (lane_q & $past(lane_set)) == $past(lane_set);
    endproperty
    a_lane_persist: assert property (p_lane_persist) else $error("persisting fault lost");

    property p_global_clear;
        global_clr && !(|lane_set) |=> lane_q == '0;
    endproperty
    a_global_clear: assert property (p_global_clear) else $error("global lane clear failed");

    property p_reset_values;
        first_q |-> (lane_q == alm_pkg::LANE_RST[NUM_LANES-1:0]) && (status_q == alm_pkg::STATUS_RST);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("wrong values after reset");

    property p_summary;
        unmasked_any ##1 unmasked_any |-> summary_q;
    endproperty
    a_summary: assert property (p_summary) else $error("summary missed unmasked flag");

    property p_summary_idle;
        !unmasked_any ##1 !unmasked_any |-> !summary_q && !alarm_irq;
    endproperty
    a_summary_idle: assert property (p_summary_idle) else $error("summary without cause");

    property p_status_lane;
        wr_status && !status_set[5] && pwdata[5] |=> !status_q[5];
    endproperty
    a_status_lane: assert property (p_status_lane) else $error("status bit 5 not cleared");

endmodule

/* alm_pkg.sv */
// alm_pkg: constants shared by the alarm aggregation block
package alm_pkg;

    // -------------------------------------------------------------------
    // bus geometry
    // -------------------------------------------------------------------
    localparam int unsigned ADDR_W  = 12;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned IDX_W   = 10;

    // -------------------------------------------------------------------
    // register indices, byte address is four times the index
    // -------------------------------------------------------------------
    localparam logic [IDX_W-1:0]  IDX_SUMMARY = 10'h2C0;
    localparam logic [IDX_W-1:0]  IDX_STATUS  = 10'h2C1;
    localparam logic [IDX_W-1:0]  IDX_MASK    = 10'h2C2;
    localparam logic [IDX_W-1:0]  IDX_LANE    = 10'h2C4;

    // -------------------------------------------------------------------
    // alarm flag bank and mask field positions
    // -------------------------------------------------------------------
    localparam int unsigned BIT_LANE    = 5;
    localparam int unsigned BIT_PLL     = 4;
    localparam int unsigned BIT_LINK    = 3;
    localparam int unsigned BIT_REALIGN = 2;
    localparam int unsigned BIT_RSVD    = 1;
    localparam int unsigned BIT_DIV     = 0;

    // -------------------------------------------------------------------
    // widths and values after reset
    // -------------------------------------------------------------------
    localparam int unsigned STATUS_W    = 6;
    localparam int unsigned REG_W       = 8;
    localparam int unsigned LANES       = 8;
    localparam int unsigned SYNC_STAGES = 2;
    localparam logic [5:0]  STATUS_RST  = 6'h3F;
    localparam logic [5:0]  SRC_BITS    = 6'h3D;
    localparam logic [7:0]  MASK_RST    = 8'h3F;
    localparam logic [7:0]  LANE_RST    = 8'hFF;
    localparam logic [7:0]  ALL_ONES_8  = 8'hFF;

endpackage

/* alm_sync.sv */
// alm_sync: two flip-flop synchroniser, one per bit
`timescale 1ns/1ns
module alm_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,     // sampling clock
    input  wire logic         rst_n,   // async reset, active low
    input  wire logic [W-1:0] d,       // asynchronous levels
    output logic      [W-1:0] q        // synchronised levels
);

    // -------------------------------------------------------------------
    // parameter check
    // -------------------------------------------------------------------
    if (W < 1) begin : g_bad_w
        $error("alm_sync: width must be at least one");
    end

    // -------------------------------------------------------------------
    // per-bit stages
    // -------------------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic meta_q;

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_q <= 1'b0;
                q[i]   <= 1'b0;
            end else begin
                meta_q <= d[i];
                q[i]   <= meta_q;
            end
        end
    end

endmodule

/* alm_w1c_bank.sv */
// alm_w1c_bank: sticky flags, hardware set wins over write-one clear
`timescale 1ns/1ns
module alm_w1c_bank #(
    parameter int unsigned W           = 8,
    parameter logic [W-1:0] RST_VALUE  = '1
) (
    input  wire logic         clk,     // register clock
    input  wire logic         rst_n,   // async reset, active low
    input  wire logic [W-1:0] set,     // per-flag set request
    input  wire logic [W-1:0] clr,     // per-flag clear request
    output logic      [W-1:0] q        // flag state
);

    // -------------------------------------------------------------------
    // parameter check
    // -------------------------------------------------------------------
    if (W < 1) begin : g_bad_w
        $error("alm_w1c_bank: width must be at least one");
    end

    // -------------------------------------------------------------------
    // flag storage
    // -------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RST_VALUE;
        end else begin
            q <= (q & ~clr) | set;
        end
    end

endmodule

/* alm_top_bench.sv */
// alm_top_bench: self-checking bench for alarm flags, source masks and lane faults
`timescale 1ns/1ns
module alm_top_bench;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    typedef struct {
        logic [12:0] src;
        logic [5:0]  flag;
    } alm_row_t;

    localparam logic [11:0] A_SUM  = {alm_pkg::IDX_SUMMARY, 2'b00};
    localparam logic [11:0] A_STA  = {alm_pkg::IDX_STATUS, 2'b00};
    localparam logic [11:0] A_MASK = {alm_pkg::IDX_MASK, 2'b00};
    localparam logic [11:0] A_LANE = {alm_pkg::IDX_LANE, 2'b00};
    localparam logic [11:0] A_BAD  = 12'hB0C;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [12:0] src;
    logic        alarm_irq;
    logic        irq_s;
    logic [31:0] rd;
    logic        err;
    int          n_mismatch;
    int          n_tests;
    int          cycles;

    // source layout: lanes[7:0], pll unlock, link enable, link running, realign, divider
    alm_row_t rows [5] = '{
        '{{8'h81, 5'b00000}, 6'h20},
        '{{8'h00, 5'b10000}, 6'h10},
        '{{8'h00, 5'b01000}, 6'h08},
        '{{8'h00, 5'b00010}, 6'h04},
        '{{8'h00, 5'b00001}, 6'h01}
    };

    alm_top i_alm_top (
        .pclk                     (pclk),
        .presetn                  (presetn),
        .psel                     (psel),
        .penable                  (penable),
        .pwrite                   (pwrite),
        .paddr                    (paddr),
        .pwdata                   (pwdata),
        .pstrb                    (pstrb),
        .prdata                   (prdata),
        .pready                   (pready),
        .pslverr                  (pslverr),
        .lane_buffer_err          (src[12:5]),
        .serdes_pll_unlock_status (src[4]),
        .link_enable              (src[3]),
        .link_running             (src[2]),
        .clock_realign_event      (src[1]),
        .divider_mismatch         (src[0]),
        .alarm_irq                (alarm_irq)
    );

    // ----------------------------------------------------------------
    // clock, settled irq sample, timeout
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(negedge pclk) irq_s <= alarm_irq;

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic wrap_up();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // request held until pready sampled high at an edge, released by the next call or idle
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
    endtask

    task automatic idle(input int n);
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        check(name, rd, exp);
    endtask

    task automatic reset_checks();
        rd_chk("status_rst", A_STA, 32'h3F);
        rd_chk("mask_rst", A_MASK, 32'h3F);
        rd_chk("lanes_rst", A_LANE, 32'hFF);
        rd_chk("summary_rst", A_SUM, 32'h0);
        idle(2);
        check("irq_rst", {31'h0, irq_s}, 32'h0);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h0;
        pwdata  = 32'h0;
        pstrb   = 4'hF;
        src     = 13'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        reset_checks();
        // one row per alarm source; sources drop again before the sticky flags are read
        for (int i = 0; i < 5; i++) begin
            apb(A_STA, 1'b1, 32'h3F);
            apb(A_MASK, 1'b1, {24'h0, 8'h3F & ~{2'b00, rows[i].flag}});
            idle(3);
            check("irq_clean", {31'h0, irq_s}, 32'h0);
            src <= rows[i].src;
            idle(5);
            src <= 13'h0;
            idle(4);
            rd_chk("status_src", A_STA, {26'h0, rows[i].flag});
            rd_chk("lanes_src", A_LANE, {24'h0, rows[i].src[12:5]});
            rd_chk("summary_on", A_SUM, 32'h1);
            idle(2);
            check("irq_on", {31'h0, irq_s}, 32'h1);
            apb(A_MASK, 1'b1, 32'h3F);
            idle(2);
            check("irq_masked", {31'h0, irq_s}, 32'h0);
            apb(A_MASK, 1'b1, {24'h0, 8'h3F & ~{2'b00, rows[i].flag}});
            idle(2);
            check("irq_unmasked", {31'h0, irq_s}, 32'h1);
            apb(A_STA, 1'b1, {26'h0, rows[i].flag});
            idle(3);
            check("irq_cleared", {31'h0, irq_s}, 32'h0);
        end
        // lane clears, persisting fault, global clear
        src <= {8'h81, 5'b00000};
        idle(4);
        src <= 13'h0;
        idle(3);
        apb(A_LANE, 1'b1, 32'h01);
        rd_chk("lane_w1c", A_LANE, 32'h80);
        apb(A_LANE, 1'b1, 32'h00);
        rd_chk("lane_w0", A_LANE, 32'h80);
        src <= {8'h08, 5'b00000};
        idle(4);
        apb(A_LANE, 1'b1, 32'h08);
        rd_chk("lane_persist", A_LANE, 32'h88);
        src <= 13'h0;
        idle(3);
        apb(A_STA, 1'b1, 32'h20);
        rd_chk("lane_global", A_LANE, 32'h00);
        rd_chk("status_global", A_STA, 32'h00);
        // byte strobe off, unmapped place, read-only summary
        pstrb <= 4'hE;
        apb(A_MASK, 1'b1, 32'h00);
        pstrb <= 4'hF;
        rd_chk("mask_nostrb", A_MASK, 32'h3E);
        apb(A_BAD, 1'b1, 32'h00);
        check("err_wr", {31'h0, err}, 32'h1);
        rd_chk("mask_keep", A_MASK, 32'h3E);
        apb(A_BAD, 1'b0, 32'h0);
        check("err_rd", {31'h0, err}, 32'h1);
        apb(A_SUM, 1'b1, 32'h1);
        check("err_sum", {31'h0, err}, 32'h0);
        // second reset in mid-run
        apb(A_MASK, 1'b1, 32'h1E);
        apb(A_LANE, 1'b1, 32'hFF);
        idle(1);
        presetn <= 1'b0;
        idle(2);
        presetn <= 1'b1;
        @(posedge pclk);
        reset_checks();
        wrap_up();
    end
endmodule
